/* hdl/ccc_pkg.sv */
// Constants, command codes and helpers shared by both ends of the
// codec channel control command port.
// Assumes both ends run on the same 100 MHz clock.
package ccc_pkg;

  // Command codes; the lowest command bit selects read
  localparam logic [7:0] CMD_MASK_WR = 8'h6c;
  localparam logic [7:0] CMD_MASK_RD = 8'h6d;
  localparam logic [7:0] CMD_OPC_WR  = 8'h70;
  localparam logic [7:0] CMD_OPC_RD  = 8'h71;
  localparam logic [7:0] CMD_REV_RD  = 8'h73;
  localparam logic [7:0] CMD_GX_WR   = 8'h80;
  localparam logic [7:0] CMD_GX_RD   = 8'h81;
  localparam logic [7:0] CMD_GR_WR   = 8'h82;
  localparam logic [7:0] CMD_GR_RD   = 8'h83;
  localparam int         RW_BIT      = 0;

  // Data byte counts
  localparam logic [1:0] LEN_NONE = 2'h0;
  localparam logic [1:0] LEN_BYTE = 2'h1;
  localparam logic [1:0] LEN_WORD = 2'h2;

  // Reset values
  localparam logic [7:0]  MASK_RST = 8'hff;
  localparam logic [7:0]  OPC_RST  = 8'h00;
  localparam logic [15:0] GX_RST   = 16'ha9f0;
  localparam logic [15:0] GR_RST   = 16'h23a1;

  // Operating conditions field positions
  localparam int OPC_TX_CUT   = 7;
  localparam int OPC_RX_CUT   = 6;
  localparam int OPC_HPF_OFF  = 5;
  localparam int OPC_RX_LOSS  = 4;
  localparam int OPC_ARM_TX   = 3;
  localparam int OPC_IF_LOOP  = 2;
  localparam int OPC_DIG_LOOP = 1;
  localparam int OPC_TONE     = 0;

  // Coefficient nibble: sign above a 3-bit shift
  localparam int NIB_W    = 4;
  localparam int SIGN_POS = 3;
  localparam int SHIFT_W  = 3;
  localparam int TERMS    = 4;

  // Gain values are signed with 28 fraction bits
  localparam logic signed [31:0] ONE_Q28 = 32'sh1000_0000;

  // Test tone timing
  localparam int CLK_HZ           = 100_000_000;
  localparam int TONE_HZ          = 1000;
  localparam int TONE_HALF_CYCLES = CLK_HZ / (2 * TONE_HZ);

  function automatic logic [1:0] cmd_len(input logic [7:0] cmd);
    case (cmd)
      CMD_MASK_WR, CMD_MASK_RD, CMD_OPC_WR, CMD_OPC_RD,
      CMD_REV_RD: cmd_len = LEN_BYTE;
      CMD_GX_WR, CMD_GX_RD, CMD_GR_WR, CMD_GR_RD: cmd_len = LEN_WORD;
      default: cmd_len = LEN_NONE;
    endcase
  endfunction

  // Nested sign/shift product, terms taken 4, 3, 2, 1
  function automatic logic signed [31:0] gain_q28(
    input logic [15:0] c,
    input logic        add_one
  );
    logic signed [31:0] t;
    logic signed [31:0] term;
    logic [2:0]         m;
    t = ONE_Q28;
    for (int i = TERMS - 1; i >= 1; i--) begin
      m = c[NIB_W * i +: SHIFT_W];
      term = t >>> m;
      t = c[NIB_W * i + SIGN_POS] ? ONE_Q28 - term : ONE_Q28 + term;
    end
    m = c[SHIFT_W - 1:0];
    term = t >>> m;
    t = c[SIGN_POS] ? -term : term;
    gain_q28 = add_one ? t + ONE_Q28 : t;
  endfunction

endpackage

/* hdl/ccc_if.sv */
// Byte-wide command port between host and codec control block.
// Assumes both ends share one clock; each strobe lasts one cycle.
interface ccc_if;
  logic [7:0] h2d_byte;
  logic       h2d_valid;
  logic [7:0] d2h_byte;
  logic       d2h_valid;

  modport dev (
    input  h2d_byte,
    input  h2d_valid,
    output d2h_byte,
    output d2h_valid
  );

  modport host (
    output h2d_byte,
    output h2d_valid,
    input  d2h_byte,
    input  d2h_valid
  );
endinterface

/* hdl/ccc_device.sv */
// Codec channel control registers behind the command port.
// Assumes the host sends no byte while a read answer is being returned.
//
// Functional notes
// - mask written 6Ch, read 6Dh, one byte
// - masked detector change never pulls interrupt low
// - mask bit 2c is A, 2c+1 is B
// - mask resets to all ones
// - mask access ignores channel enable setting
// - conditions 70h/71h, eight fields, reset zero
// - cut bits disconnect transmit or receive path
// - receive cutoff also disables balance filter
// - highpass active at 0, bypassed at 1
// - loopback bit routes full digital loopback
// - tone bit injects 1 kHz receive tone
// - 73h returns revision byte, always
// - transmit gain 80h/81h, two nibble-coded bytes
// - sign bit 0 is plus, 1 minus
// - transmit gain is one plus nested product
// - fixed defaults kept apart from programmed words
// - receive gain 82h/83h, no leading one
// - select bit 0 default, 1 programmed
module ccc_device #(
  parameter int         TONE_HALF_CYCLES = ccc_pkg::TONE_HALF_CYCLES,
  // Arbitrary revision value
  parameter logic [7:0] REV_CODE         = 8'h5a,
  parameter int         DET_BITS         = 8
) (
  // Command port
  ccc_if.dev                 port,
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          reset,
  // Detector pins and gain source selects
  input  wire logic [DET_BITS-1:0] detect_input_bit,
  input  wire logic          tx_gain_custom_select,
  input  wire logic          rx_gain_custom_select,
  // Interrupt and mask
  output logic               irq_n,
  output logic [3:0]         mask_detect_a_bits,
  output logic [3:0]         mask_detect_b_bits,
  // Channel operating conditions
  output logic               tx_path_cut,
  output logic               rx_path_cut,
  output logic               b_filter_on,
  output logic               tx_highpass_on,
  output logic               rx_loss_insert,
  output logic               arm_xmit_irq,
  output logic               interface_loopback,
  output logic               full_digital_loopback,
  output logic               receive_1khz_signal,
  // Gain coefficients in use and their values
  output logic [15:0]        transmit_gain_filter,
  output logic [15:0]        receive_gain_filter,
  output logic signed [31:0] tx_gain_value,
  output logic signed [31:0] rx_gain_value
);

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_WDATA = 2'b01,
    ST_RDATA = 2'b10
  } ccc_state_e;

  localparam int TCW = $clog2(TONE_HALF_CYCLES + 1);

  ccc_state_e         state_reg;
  logic [7:0]         cmd_reg;
  logic [1:0]         cnt_reg;
  logic [7:0]         wr_hi_reg;
  logic [7:0]         rd_lo_reg;
  logic [7:0]         d2h_byte_reg;
  logic               d2h_valid_reg;
  logic [7:0]         mask_reg;
  logic [7:0]         opc_reg;
  logic               b_on_reg;
  logic               hp_on_reg;
  logic [15:0]        gx_reg;
  logic [15:0]        gr_reg;
  logic [15:0]        gx_use_reg;
  logic [15:0]        gr_use_reg;
  logic signed [31:0] gx_val_reg;
  logic signed [31:0] gr_val_reg;
  logic [DET_BITS-1:0] det_s1_reg;
  logic [DET_BITS-1:0] det_s2_reg;
  logic [DET_BITS-1:0] det_prev_reg;
  logic [DET_BITS-1:0] pend_reg;
  logic               irq_n_reg;
  logic [TCW-1:0]     tone_cnt_reg;
  logic               tone_reg;

  logic               cmd_take;
  logic [1:0]         cmd_len;
  logic [15:0]        rd_word;
  logic               wr_commit;
  logic [15:0]        wr_word;
  logic               mask_touch;

  // Fixed defaults held apart from the programmed words
  localparam logic [15:0] GX_ROM = ccc_pkg::GX_RST;
  localparam logic [15:0] GR_ROM = ccc_pkg::GR_RST;

  // No channel enable input exists, so decode never depends on one
  assign cmd_take = (state_reg == ST_IDLE) && port.h2d_valid;
  assign cmd_len  = ccc_pkg::cmd_len(port.h2d_byte);
  assign wr_commit = (state_reg == ST_WDATA) && port.h2d_valid &&
                     (cnt_reg == ccc_pkg::LEN_BYTE);
  assign wr_word  = {wr_hi_reg, port.h2d_byte};
  assign mask_touch = cmd_take &&
    ((port.h2d_byte == ccc_pkg::CMD_MASK_WR) ||
     (port.h2d_byte == ccc_pkg::CMD_MASK_RD));

  // Read data; byte registers sit in the low byte
  always_comb begin
    case (port.h2d_byte)
      ccc_pkg::CMD_MASK_RD: rd_word = {8'h00, mask_reg};
      ccc_pkg::CMD_OPC_RD:  rd_word = {8'h00, opc_reg};
      ccc_pkg::CMD_REV_RD:  rd_word = {8'h00, REV_CODE};
      ccc_pkg::CMD_GX_RD:   rd_word = gx_reg;
      ccc_pkg::CMD_GR_RD:   rd_word = gr_reg;
      default:              rd_word = 16'h0000;
    endcase
  end

  // Command sequencer
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg     <= ST_IDLE;
      cmd_reg       <= 8'h00;
      cnt_reg       <= ccc_pkg::LEN_NONE;
      wr_hi_reg     <= 8'h00;
      rd_lo_reg     <= 8'h00;
      d2h_byte_reg  <= 8'h00;
      d2h_valid_reg <= 1'b0;
    end else begin
      d2h_valid_reg <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (cmd_take && cmd_len != ccc_pkg::LEN_NONE) begin
            cmd_reg <= port.h2d_byte;
            cnt_reg <= cmd_len;
            if (port.h2d_byte[ccc_pkg::RW_BIT]) begin
              d2h_valid_reg <= 1'b1;
              rd_lo_reg     <= rd_word[7:0];
              if (cmd_len == ccc_pkg::LEN_WORD) begin
                d2h_byte_reg <= rd_word[15:8];
                state_reg    <= ST_RDATA;
              end else begin
                d2h_byte_reg <= rd_word[7:0];
              end
            end else begin
              state_reg <= ST_WDATA;
            end
          end
        end
        ST_WDATA: begin
          if (port.h2d_valid) begin
            wr_hi_reg <= port.h2d_byte;
            cnt_reg   <= cnt_reg - ccc_pkg::LEN_BYTE;
            if (cnt_reg == ccc_pkg::LEN_BYTE) begin
              state_reg <= ST_IDLE;
            end
          end
        end
        ST_RDATA: begin
          d2h_byte_reg  <= rd_lo_reg;
          d2h_valid_reg <= 1'b1;
          state_reg     <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Interrupt mask
  always_ff @(posedge clk) begin
    if (reset) begin
      mask_reg <= ccc_pkg::MASK_RST;
    end else if (wr_commit && cmd_reg == ccc_pkg::CMD_MASK_WR) begin
      mask_reg <= wr_word[7:0];
    end
  end

  // Operating conditions
  always_ff @(posedge clk) begin
    if (reset) begin
      opc_reg   <= ccc_pkg::OPC_RST;
      b_on_reg  <= ~ccc_pkg::OPC_RST[ccc_pkg::OPC_RX_CUT];
      hp_on_reg <= ~ccc_pkg::OPC_RST[ccc_pkg::OPC_HPF_OFF];
    end else if (wr_commit && cmd_reg == ccc_pkg::CMD_OPC_WR) begin
      opc_reg   <= wr_word[7:0];
      b_on_reg  <= ~wr_word[ccc_pkg::OPC_RX_CUT];
      hp_on_reg <= ~wr_word[ccc_pkg::OPC_HPF_OFF];
    end
  end

  // Programmed gain coefficients
  always_ff @(posedge clk) begin
    if (reset) begin
      gx_reg <= ccc_pkg::GX_RST;
      gr_reg <= ccc_pkg::GR_RST;
    end else if (wr_commit) begin
      if (cmd_reg == ccc_pkg::CMD_GX_WR) begin
        gx_reg <= wr_word;
      end
      if (cmd_reg == ccc_pkg::CMD_GR_WR) begin
        gr_reg <= wr_word;
      end
    end
  end

  // Gain source selection and evaluation
  always_ff @(posedge clk) begin
    if (reset) begin
      gx_use_reg <= GX_ROM;
      gr_use_reg <= GR_ROM;
      gx_val_reg <= ccc_pkg::ONE_Q28;
      gr_val_reg <= ccc_pkg::ONE_Q28;
    end else begin
      gx_use_reg <= tx_gain_custom_select ? gx_reg : GX_ROM;
      gr_use_reg <= rx_gain_custom_select ? gr_reg : GR_ROM;
      gx_val_reg <= ccc_pkg::gain_q28(gx_use_reg, 1'b1);
      gr_val_reg <= ccc_pkg::gain_q28(gr_use_reg, 1'b0);
    end
  end

  // Detector synchroniser and change capture
  always_ff @(posedge clk) begin
    if (reset) begin
      det_s1_reg   <= '0;
      det_s2_reg   <= '0;
      det_prev_reg <= '0;
    end else begin
      det_s1_reg   <= detect_input_bit;
      det_s2_reg   <= det_s1_reg;
      det_prev_reg <= det_s2_reg;
    end
  end

  // Pending change per detector bit; a new change beats the clear
  for (genvar b = 0; b < DET_BITS; b++) begin : g_pend
    always_ff @(posedge clk) begin
      if (reset) begin
        pend_reg[b] <= 1'b0;
      end else if ((det_s2_reg[b] ^ det_prev_reg[b]) && !mask_reg[b]) begin
        pend_reg[b] <= 1'b1;
      end else if (mask_touch) begin
        pend_reg[b] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      irq_n_reg <= 1'b1;
    end else begin
      irq_n_reg <= ~|(pend_reg & ~mask_reg);
    end
  end

  // Test tone square wave
  always_ff @(posedge clk) begin
    if (reset || !opc_reg[ccc_pkg::OPC_TONE]) begin
      tone_cnt_reg <= '0;
      tone_reg     <= 1'b0;
    end else if (tone_cnt_reg == TCW'(TONE_HALF_CYCLES - 1)) begin
      tone_cnt_reg <= '0;
      tone_reg     <= ~tone_reg;
    end else begin
      tone_cnt_reg <= tone_cnt_reg + 1'b1;
    end
  end

  assign port.d2h_byte  = d2h_byte_reg;
  assign port.d2h_valid = d2h_valid_reg;
  assign irq_n          = irq_n_reg;
  for (genvar c = 0; c < 4; c++) begin : g_mask
    assign mask_detect_a_bits[c] = mask_reg[2 * c];
    assign mask_detect_b_bits[c] = mask_reg[2 * c + 1];
  end
  assign tx_path_cut           = opc_reg[ccc_pkg::OPC_TX_CUT];
  assign rx_path_cut           = opc_reg[ccc_pkg::OPC_RX_CUT];
  assign b_filter_on           = b_on_reg;
  assign tx_highpass_on        = hp_on_reg;
  assign rx_loss_insert        = opc_reg[ccc_pkg::OPC_RX_LOSS];
  assign arm_xmit_irq          = opc_reg[ccc_pkg::OPC_ARM_TX];
  assign interface_loopback    = opc_reg[ccc_pkg::OPC_IF_LOOP];
  assign full_digital_loopback = opc_reg[ccc_pkg::OPC_DIG_LOOP];
  assign receive_1khz_signal   = tone_reg;
  assign transmit_gain_filter  = gx_use_reg;
  assign receive_gain_filter   = gr_use_reg;
  assign tx_gain_value         = gx_val_reg;
  assign rx_gain_value         = gr_val_reg;

endmodule

/* hdl/ccc_host.sv */
// Host end of the command port: sends one command with its data
// bytes, or collects the read answer, per user request.
// Assumes the device answers a read in the cycles right after it.
module ccc_host (
  // Command port
  ccc_if.host              port,
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // User request
  input  wire logic        req_valid,
  input  wire logic [7:0]  req_cmd,
  input  wire logic [15:0] req_wdata,
  output logic             req_ready,
  // User response
  output logic             resp_valid,
  output logic [15:0]      resp_data
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01,
    ST_RECV = 2'b10
  } ccc_hstate_e;

  ccc_hstate_e state_reg;
  logic [1:0]  cnt_reg;
  logic [15:0] buf_reg;
  logic [7:0]  h2d_byte_reg;
  logic        h2d_valid_reg;
  logic        ready_reg;
  logic        resp_valid_reg;
  logic [15:0] resp_data_reg;
  logic [1:0]  len;

  assign len = ccc_pkg::cmd_len(req_cmd);

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg      <= ST_IDLE;
      cnt_reg        <= ccc_pkg::LEN_NONE;
      buf_reg        <= 16'h0000;
      h2d_byte_reg   <= 8'h00;
      h2d_valid_reg  <= 1'b0;
      ready_reg      <= 1'b1;
      resp_valid_reg <= 1'b0;
      resp_data_reg  <= 16'h0000;
    end else begin
      h2d_valid_reg  <= 1'b0;
      resp_valid_reg <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (req_valid) begin
            h2d_byte_reg  <= req_cmd;
            h2d_valid_reg <= 1'b1;
            cnt_reg       <= len;
            buf_reg       <= 16'h0000;
            if (len == ccc_pkg::LEN_NONE) begin
              resp_valid_reg <= 1'b1;
              resp_data_reg  <= 16'h0000;
            end else if (req_cmd[ccc_pkg::RW_BIT]) begin
              ready_reg <= 1'b0;
              state_reg <= ST_RECV;
            end else begin
              ready_reg <= 1'b0;
              state_reg <= ST_SEND;
              // High byte goes first for words
              buf_reg <= (len == ccc_pkg::LEN_WORD) ? req_wdata :
                         {req_wdata[7:0], 8'h00};
            end
          end
        end
        ST_SEND: begin
          h2d_byte_reg  <= buf_reg[15:8];
          h2d_valid_reg <= 1'b1;
          buf_reg       <= {buf_reg[7:0], 8'h00};
          cnt_reg       <= cnt_reg - ccc_pkg::LEN_BYTE;
          if (cnt_reg == ccc_pkg::LEN_BYTE) begin
            state_reg      <= ST_IDLE;
            ready_reg      <= 1'b1;
            resp_valid_reg <= 1'b1;
            resp_data_reg  <= 16'h0000;
          end
        end
        ST_RECV: begin
          if (port.d2h_valid) begin
            buf_reg <= {buf_reg[7:0], port.d2h_byte};
            cnt_reg <= cnt_reg - ccc_pkg::LEN_BYTE;
            if (cnt_reg == ccc_pkg::LEN_BYTE) begin
              state_reg      <= ST_IDLE;
              ready_reg      <= 1'b1;
              resp_valid_reg <= 1'b1;
              resp_data_reg  <= {buf_reg[7:0], port.d2h_byte};
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  assign port.h2d_byte  = h2d_byte_reg;
  assign port.h2d_valid = h2d_valid_reg;
  assign req_ready      = ready_reg;
  assign resp_valid     = resp_valid_reg;
  assign resp_data      = resp_data_reg;

endmodule

/* verification/ccc_props.sv */
// Concurrent checks on the byte-wide command port.
// Assumes it watches the link joining ccc_host and ccc_device.
module ccc_props #(
  parameter logic [7:0] REV_CODE = 8'h5a
) (
  // Clock and reset
  input wire logic       clk,
  input wire logic       reset,
  // Command port
  input wire logic [7:0] h2d_byte,
  input wire logic       h2d_valid,
  input wire logic [7:0] d2h_byte,
  input wire logic       d2h_valid
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [1:0] left_reg;
  logic [3:0] wrote_reg;
  logic       cmd;

  // A byte is a command when no write data is still owed
  assign cmd = h2d_valid && left_reg == 2'h0;

  always_ff @(posedge clk) begin
    if (reset) begin
      left_reg <= 2'h0;
    end else if (h2d_valid) begin
      if (left_reg != 2'h0) begin
        left_reg <= left_reg - 2'h1;
      end else begin
        left_reg <= h2d_byte[0] ? 2'h0 : ccc_pkg::cmd_len(h2d_byte);
      end
    end
  end

  // Registers written since reset
  always_ff @(posedge clk) begin
    if (reset) begin
      wrote_reg <= 4'h0;
    end else if (cmd) begin
      if (h2d_byte == ccc_pkg::CMD_MASK_WR) wrote_reg[0] <= 1'b1;
      if (h2d_byte == ccc_pkg::CMD_OPC_WR) wrote_reg[1] <= 1'b1;
      if (h2d_byte == ccc_pkg::CMD_GX_WR) wrote_reg[2] <= 1'b1;
      if (h2d_byte == ccc_pkg::CMD_GR_WR) wrote_reg[3] <= 1'b1;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  property p_mask_rd;
    cmd && h2d_byte == ccc_pkg::CMD_MASK_RD |=> d2h_valid ##1 !d2h_valid;
  endproperty
  a_mask_rd: assert property (p_mask_rd) else $error("mask read");

  property p_mask_rst;
    cmd && h2d_byte == ccc_pkg::CMD_MASK_RD && !wrote_reg[0]
      |=> d2h_byte == ccc_pkg::MASK_RST;
  endproperty
  a_mask_rst: assert property (p_mask_rst) else $error("mask reset");

  property p_opc_rst;
    cmd && h2d_byte == ccc_pkg::CMD_OPC_RD && !wrote_reg[1]
      |=> d2h_valid && d2h_byte == ccc_pkg::OPC_RST ##1 !d2h_valid;
  endproperty
  a_opc_rst: assert property (p_opc_rst) else $error("opc reset");

  property p_rev;
    cmd && h2d_byte == ccc_pkg::CMD_REV_RD
      |=> d2h_valid && d2h_byte == REV_CODE ##1 !d2h_valid;
  endproperty
  a_rev: assert property (p_rev) else $error("revision byte");

  property p_gx_rst;
    cmd && h2d_byte == ccc_pkg::CMD_GX_RD && !wrote_reg[2]
      |=> d2h_valid && d2h_byte == ccc_pkg::GX_RST[15:8]
      ##1 d2h_valid && d2h_byte == ccc_pkg::GX_RST[7:0] ##1 !d2h_valid;
  endproperty
  a_gx_rst: assert property (p_gx_rst) else $error("gx reset");

  property p_gr_rst;
    cmd && h2d_byte == ccc_pkg::CMD_GR_RD && !wrote_reg[3]
      |=> d2h_byte == ccc_pkg::GR_RST[15:8]
      ##1 d2h_byte == ccc_pkg::GR_RST[7:0];
  endproperty
  a_gr_rst: assert property (p_gr_rst) else $error("gr reset");

  property p_gr_rd;
    cmd && h2d_byte == ccc_pkg::CMD_GR_RD |=> d2h_valid[*2] ##1 !d2h_valid;
  endproperty
  a_gr_rd: assert property (p_gr_rd) else $error("gr read length");

  property p_wr_quiet;
    cmd && !h2d_byte[0] |=> !d2h_valid[*2];
  endproperty
  a_wr_quiet: assert property (p_wr_quiet) else $error("write answered");

  property p_cause;
    $rose(d2h_valid) |-> $past(cmd) && $past(h2d_byte[0]);
  endproperty
  a_cause: assert property (p_cause) else $error("answer without read");

  c_gx_rd: cover property (cmd && h2d_byte == ccc_pkg::CMD_GX_RD);
  c_mask_wr: cover property (cmd && h2d_byte == ccc_pkg::CMD_MASK_WR);
  c_rev: cover property (cmd && h2d_byte == ccc_pkg::CMD_REV_RD);
endmodule

/* verification/ccc_tb_top.sv */
// Self-checking bench: host and device joined by the command port.
// Assumes one 100 MHz clock and synchronous active-high reset.
module ccc_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  // Arbitrary revision value
  localparam logic [7:0] REV  = 8'h3c;
  localparam int         HALF = 5;

  logic               clk;
  logic               reset;
  logic               req_valid;
  logic [7:0]         req_cmd;
  logic [15:0]        req_wdata;
  logic               req_ready;
  logic               resp_valid;
  logic [15:0]        resp_data;
  logic [15:0]        r;
  logic [7:0]         det;
  logic               tx_sel;
  logic               rx_sel;
  logic               irq_n;
  logic [3:0]         mask_a;
  logic [3:0]         mask_b;
  logic               tx_cut, rx_cut, b_on, hp_on, loss, arm;
  logic               if_loop, dig_loop, tone;
  logic [7:0]         opc_vec;
  logic [15:0]        gx_use;
  logic [15:0]        gr_use;
  logic signed [31:0] gx_val;
  logic signed [31:0] gr_val;
  int                 n_mismatch = 0;
  int                 checks_done = 0;

  assign opc_vec = {tx_cut, rx_cut, !hp_on, loss, arm, if_loop, dig_loop, tone};

  ccc_if link ();

  ccc_host u_ccc_host (
    .port(link), .clk(clk), .reset(reset), .req_valid(req_valid),
    .req_cmd(req_cmd), .req_wdata(req_wdata), .req_ready(req_ready),
    .resp_valid(resp_valid), .resp_data(resp_data)
  );

  ccc_device #(.TONE_HALF_CYCLES(HALF), .REV_CODE(REV)) u_ccc_device (
    .port(link), .clk(clk), .reset(reset), .detect_input_bit(det),
    .tx_gain_custom_select(tx_sel), .rx_gain_custom_select(rx_sel),
    .irq_n(irq_n), .mask_detect_a_bits(mask_a), .mask_detect_b_bits(mask_b),
    .tx_path_cut(tx_cut), .rx_path_cut(rx_cut), .b_filter_on(b_on),
    .tx_highpass_on(hp_on), .rx_loss_insert(loss), .arm_xmit_irq(arm),
    .interface_loopback(if_loop), .full_digital_loopback(dig_loop),
    .receive_1khz_signal(tone), .transmit_gain_filter(gx_use),
    .receive_gain_filter(gr_use), .tx_gain_value(gx_val),
    .rx_gain_value(gr_val)
  );

  ccc_props #(.REV_CODE(REV)) u_ccc_props (
    .clk(clk), .reset(reset), .h2d_byte(link.h2d_byte),
    .h2d_valid(link.h2d_valid), .d2h_byte(link.d2h_byte),
    .d2h_valid(link.d2h_valid)
  );

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: gain %h expected %h", $time, got, exp);
    end
  endtask

  // One host request; called and left at a falling edge
  task automatic xfer(input logic [7:0] c, input logic [15:0] wd,
                      output logic [15:0] rd);
    for (int i = 0; i < 20 && req_ready !== 1'b1; i++) @(negedge clk);
    req_valid = 1'b1;
    req_cmd = c;
    req_wdata = wd;
    @(negedge clk);
    req_valid = 1'b0;
    for (int i = 0; i < 10 && resp_valid !== 1'b1; i++) @(negedge clk);
    chk16({15'h0, resp_valid}, 16'h0001);
    rd = resp_data;
    repeat (2) @(negedge clk);
  endtask

  task automatic t_reset();
    chk16({8'h0, mask_b, mask_a}, 16'h00ff);
    chk16({8'h0, opc_vec}, 16'h0000);
    chk16({15'h0, b_on}, 16'h0001);
    chk16(gx_use, 16'ha9f0);
    chk16(gr_use, 16'h23a1);
    chk32(gx_val, 32'h1fec0000);
    chk32(gr_val, 32'h05b00000);
    xfer(8'h6d, 16'h0000, r);
    chk16(r, 16'h00ff);
    xfer(8'h71, 16'h0000, r);
    chk16(r, 16'h0000);
    xfer(8'h81, 16'h0000, r);
    chk16(r, 16'ha9f0);
    xfer(8'h83, 16'h0000, r);
    chk16(r, 16'h23a1);
    xfer(8'h73, 16'h0000, r);
    chk16(r, {8'h0, REV});
  endtask

  task automatic t_mask();
    xfer(8'h6c, 16'h005a, r);
    chk16({8'h0, mask_b, mask_a}, 16'h003c);
    xfer(8'h6b, 16'h00a5, r);
    xfer(8'h6d, 16'h0000, r);
    chk16(r, 16'h005a);
  endtask

  task automatic irq_case(input logic [7:0] m, input int idx,
                          input logic low);
    xfer(8'h6c, {8'h0, m}, r);
    det[idx] = ~det[idx];
    repeat (8) @(negedge clk);
    chk16({15'h0, irq_n}, {15'h0, ~low});
  endtask

  task automatic t_opc();
    logic [7:0] v;
    int         hi;
    for (int i = 1; i < 8; i++) begin
      v = 8'h01 << i;
      xfer(8'h70, {8'h0, v}, r);
      chk16({8'h0, opc_vec}, {8'h0, v});
      chk16({15'h0, b_on}, {15'h0, ~v[6]});
      xfer(8'h71, 16'h0000, r);
      chk16(r, {8'h0, v});
    end
    for (int k = 1; k >= 0; k--) begin
      xfer(8'h70, 16'(k), r);
      hi = 0;
      repeat (2 * HALF) begin
        @(negedge clk);
        hi += int'(tone === 1'b1);
      end
      chk16(16'(hi), 16'(k * HALF));
    end
  endtask

  task automatic t_gain();
    xfer(8'h80, 16'h0000, r);
    xfer(8'h82, 16'h0008, r);
    xfer(8'h81, 16'h0000, r);
    chk16(r, 16'h0000);
    xfer(8'h83, 16'h0000, r);
    chk16(r, 16'h0008);
    chk16(gx_use, 16'ha9f0);
    tx_sel = 1'b1;
    rx_sel = 1'b1;
    repeat (3) @(negedge clk);
    chk16(gx_use, 16'h0000);
    chk16(gr_use, 16'h0008);
    chk32(gx_val, 32'h50000000);
    chk32(gr_val, 32'hc0000000);
    tx_sel = 1'b0;
    repeat (3) @(negedge clk);
    chk32(gx_val, 32'h1fec0000);
  endtask

  task automatic stop_test();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    reset = 1'b1;
    req_valid = 1'b0;
    req_cmd = 8'h00;
    req_wdata = 16'h0000;
    det = 8'h00;
    tx_sel = 1'b0;
    rx_sel = 1'b0;
    repeat (10) @(negedge clk);
    reset = 1'b0;
    @(negedge clk);
    t_reset();
    t_mask();
    irq_case(8'hfe, 0, 1'b1);
    irq_case(8'hff, 0, 1'b0);
    irq_case(8'h7f, 7, 1'b1);
    t_opc();
    t_gain();
    stop_test();
  end

  initial begin
    repeat (6000) @(posedge clk);
    n_mismatch++;
    stop_test();
  end
endmodule
